// *** src/fault_lock.sv ***
`timescale 1ns/1ps
module fault_lock
  import laser_fault_pkg::*;
#(
  parameter int LOCK_CYC = LOCK_CYCLES
) (
  input  wire logic   sys_clk_i,
  input  wire logic   nrst_i,
  fault_lock_if.lock  lk
);
  typedef struct packed {
    lock_state_t           st;
    logic                  tx_prev;
    logic [LOCK_CNT_W-1:0] cnt;
  } lock_regs_t;

  localparam logic [LOCK_CNT_W-1:0] CNT_LAST = LOCK_CNT_W'(LOCK_CYC - 1);

  lock_regs_t r_reg;
  lock_regs_t r_next;

  always_comb begin
    r_next         = r_reg;
    r_next.tx_prev = lk.tx_on;
    case (r_reg.st)
      LK_IDLE: begin
        if (lk.lock_en && lk.fault_evt) begin
          r_next.st = LK_ONCE;
        end
      end
      LK_ONCE: begin
        // the single permitted clear: a fresh enable edge
        if (lk.tx_on && !r_reg.tx_prev) begin
          r_next.st  = LK_WATCH;
          r_next.cnt = '0;
        end
      end
      LK_WATCH: begin
        r_next.cnt = r_reg.cnt + 1'b1;
        if (lk.fault_evt) begin
          r_next.st = LK_LOCKED;
        end else if (r_reg.cnt == CNT_LAST) begin
          r_next.st = LK_IDLE;
        end
      end
      LK_LOCKED: r_next.st = LK_LOCKED; // only power cycling leaves here
      default:   r_next.st = LK_IDLE;
    endcase
    if (!lk.lock_en && r_reg.st != LK_LOCKED) begin
      r_next.st = LK_IDLE;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign lk.locked       = (r_reg.st == LK_LOCKED);
  assign lk.faulted_once = (r_reg.st == LK_ONCE) || (r_reg.st == LK_WATCH);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  a_lock_sticks: assert property (lk.locked |=> lk.locked)
    else $error("lock released without power cycle");
  a_second_fault: assert property (
    (r_reg.st == LK_WATCH && lk.fault_evt && lk.lock_en) |=> lk.locked)
    else $error("second fault in window did not lock");
  a_window_clear: assert property (
    (r_reg.st == LK_WATCH && r_reg.cnt == CNT_LAST && !lk.fault_evt && lk.lock_en)
      |=> !lk.faulted_once && !lk.locked)
    else $error("quiet window did not clear first fault");
  a_no_lock_free: assert property (
    (!lk.lock_en && !lk.locked) |=> !lk.locked && !lk.faulted_once)
    else $error("lock taken while repeat lock off");
endmodule : fault_lock

// *** src/fault_lock_if.sv ***
`timescale 1ns/1ps
interface fault_lock_if;
  logic fault_evt;
  logic tx_on;
  logic lock_en;
  logic locked;
  logic faulted_once;
  modport ctrl (output fault_evt, output tx_on, output lock_en,
                input locked, input faulted_once);
  modport lock (input fault_evt, input tx_on, input lock_en,
                output locked, output faulted_once);
endinterface : fault_lock_if

// *** src/laser_fault_ctrl.sv ***
`timescale 1ns/1ps
// Operation
// - lock bit: second fault within 25ms locks off
// - lock clear: unlimited fault clear attempts
// - no fast resume: servo values zeroed when disabled
// - fast resume: retained servo values loaded on enable with loop on
// - drive select picks open drain, pullups, push-pull
// - loop off: host writes current settings
// - loop on: loop overwrites current settings
// - auto shutdown off: keep driving after fault
// - auto shutdown on: fault disables transmitter
// - polarity bit selects alarm active level
// - no override: fault drives alarm active
// - override: faults latched, alarm ignores them and follows the force bit
// - force bit sets alarm level under override
// - overpower detection gated by enable bit
// - underpower detection gated by enable bit
// - overcurrent detection gated by enable bit
// - enabled needs pin, soft bit, no lock, and no fault when auto shutdown is on
// - quiet 25ms after re-enable clears first fault
module laser_fault_ctrl
  import laser_fault_pkg::*;
#(
  parameter int LOCK_CYC = LOCK_CYCLES
) (
  input  wire logic             sys_clk_i,
  input  wire logic             nrst_i,
  input  wire logic             tx_en_pin_i,
  input  wire logic             over_power_i,
  input  wire logic             under_power_i,
  input  wire logic             over_current_i,
  input  wire logic [DAC_W-1:0] loop_bias_i,
  input  wire logic [DAC_W-1:0] loop_mod_i,
  input  wire logic [7:0]       cmd_code_i,
  input  wire logic             cmd_wr_i,
  input  wire logic             cmd_rd_i,
  input  wire logic [15:0]      cmd_wdata_i,
  output logic [15:0]           cmd_rdata_o,
  output logic                  cmd_rvalid_o,
  output logic                  tx_enabled_o,
  output logic [DAC_W-1:0]      bias_current_setting_o,
  output logic [DAC_W-1:0]      modulation_current_setting_o,
  output logic                  faulted_o,
  output logic                  faulted_once_o,
  output logic                  faulted_twice_o,
  output logic                  alarm_out_o,
  output logic                  alarm_oe_n_o,
  output logic                  alarm_weak_pullup_o,
  output logic                  alarm_strong_pullup_o
);
  typedef struct packed {
    logic [3:0]         syn1;
    logic [3:0]         syn2;
    logic [SETUP_W-1:0] setup;
    logic               soft_en;
    logic               tx_on;
    logic               faulted;
    logic [DAC_W-1:0]   bias;
    logic [DAC_W-1:0]   modc;
    logic [DAC_W-1:0]   servo_bias;
    logic [DAC_W-1:0]   servo_mod;
    logic [15:0]        rdata;
    logic               rvalid;
    logic               alarm_out;
    logic               alarm_oe_n;
    logic               pu_weak;
    logic               pu_strong;
  } ctrl_regs_t;

  ctrl_regs_t r_reg;
  ctrl_regs_t r_next;

  fault_lock_if lk ();

  logic       pin_en;
  logic [2:0] det;
  logic       fault_evt;
  logic       want_on;
  logic [1:0] drv;
  logic       alarm_act;
  logic       alarm_lvl;

  assign pin_en = r_reg.syn2[SYN_PIN];
  assign det    = r_reg.syn2[SYN_OP:SYN_OC] &
                  {r_reg.setup[BIT_OVER_PWR],
                   r_reg.setup[BIT_UNDER_PWR],
                   r_reg.setup[BIT_OVER_CUR]};
  assign fault_evt = |det;
  // host turns the laser off by pin or soft bit
  assign want_on = pin_en && r_reg.soft_en;
  assign drv     = r_reg.setup[BIT_DRV_HI:BIT_DRV_LO];

  assign lk.fault_evt = fault_evt;
  assign lk.tx_on     = r_reg.tx_on;
  assign lk.lock_en   = r_reg.setup[BIT_REP_LOCK];

  // lock sequencing sits apart so a test can shorten its window
  fault_lock #(
    .LOCK_CYC (LOCK_CYC)
  ) u_lock (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .lk        (lk.lock)
  );

  always_comb begin
    r_next      = r_reg;
    alarm_act   = 1'b0;
    alarm_lvl   = 1'b0;
    // pin and detectors are asynchronous: two stages before use
    r_next.syn1 = {over_power_i, under_power_i, over_current_i, tx_en_pin_i};
    r_next.syn2 = r_reg.syn1;

    // fault latch: a new fault wins over the host's clear
    if (fault_evt) begin
      r_next.faulted = 1'b1;
    end else if (!want_on && !lk.locked) begin
      r_next.faulted = 1'b0;
    end

    // auto shutdown gates only when enabled; otherwise keep driving
    r_next.tx_on = want_on && !lk.locked &&
                   !((r_next.faulted) && r_reg.setup[BIT_AUTO_SD]);

    // host writes
    if (cmd_wr_i) begin
      case (cmd_code_i)
        CMD_FAULT_SETUP: r_next.setup = cmd_wdata_i[SETUP_W-1:0];
        CMD_SYS_SETUP:   r_next.soft_en = cmd_wdata_i[BIT_SOFT_EN];
        CMD_BIAS_SET:    r_next.bias = cmd_wdata_i[DAC_W-1:0];
        CMD_MOD_SET:     r_next.modc = cmd_wdata_i[DAC_W-1:0];
        default:         r_next.rvalid = r_reg.rvalid;
      endcase
    end

    // servo copies and current settings
    if (r_reg.tx_on) begin
      if (r_reg.setup[BIT_LOOP_EN]) begin
        r_next.bias       = loop_bias_i;
        r_next.modc       = loop_mod_i;
        r_next.servo_bias = loop_bias_i;
        r_next.servo_mod  = loop_mod_i;
      end
    end else if (!r_reg.setup[BIT_FAST_RESUME]) begin
      r_next.servo_bias = '0;
      r_next.servo_mod  = '0;
    end
    if (r_next.tx_on && !r_reg.tx_on && r_reg.setup[BIT_LOOP_EN]) begin
      // restart point: zeros, or retained values under fast resume
      r_next.bias = r_next.servo_bias;
      r_next.modc = r_next.servo_mod;
    end

    // read path: one cycle behind the request
    r_next.rvalid = cmd_rd_i;
    r_next.rdata  = '0;
    if (cmd_rd_i) begin
      case (cmd_code_i)
        CMD_FAULT_SETUP: r_next.rdata = {4'h0, r_reg.setup};
        CMD_SYS_SETUP:   r_next.rdata = {15'h0000, r_reg.soft_en};
        CMD_BIAS_SET:    r_next.rdata = r_reg.bias;
        CMD_MOD_SET:     r_next.rdata = r_reg.modc;
        default:         r_next.rdata = '0;
      endcase
    end

    // alarm pin
    if (r_reg.setup[BIT_OVERRIDE]) begin
      alarm_act = r_reg.setup[BIT_FORCE];
    end else begin
      alarm_act = r_reg.faulted;
    end
    alarm_lvl = r_reg.setup[BIT_POLARITY] ? alarm_act : !alarm_act;
    r_next.pu_weak   = (drv == DRV_PULL_WEAK);
    r_next.pu_strong = (drv == DRV_PULL_STRONG);
    if (drv == DRV_PUSH_PULL) begin
      r_next.alarm_out  = alarm_lvl;
      r_next.alarm_oe_n = 1'b0;
    end else begin
      // open drain: only ever pulls low
      r_next.alarm_out  = 1'b0;
      r_next.alarm_oe_n = alarm_lvl;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      r_reg            <= '0;
      r_reg.setup      <= SETUP_RESET;
      r_reg.soft_en    <= SOFT_EN_RESET;
      r_reg.alarm_oe_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign cmd_rdata_o                  = r_reg.rdata;
  assign cmd_rvalid_o                 = r_reg.rvalid;
  assign tx_enabled_o                 = r_reg.tx_on;
  assign bias_current_setting_o       = r_reg.bias;
  assign modulation_current_setting_o = r_reg.modc;
  assign faulted_o                    = r_reg.faulted;
  assign faulted_once_o               = lk.faulted_once;
  assign faulted_twice_o              = lk.locked;
  assign alarm_out_o                  = r_reg.alarm_out;
  assign alarm_oe_n_o                 = r_reg.alarm_oe_n;
  assign alarm_weak_pullup_o          = r_reg.pu_weak;
  assign alarm_strong_pullup_o        = r_reg.pu_strong;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  a_auto_shutdown: assert property (
    (fault_evt && r_reg.setup[BIT_AUTO_SD]) |=> !tx_enabled_o)
    else $error("fault did not shut transmitter");
  a_keep_driving: assert property (
    (tx_enabled_o && want_on && !r_reg.setup[BIT_AUTO_SD] && !lk.locked)
      |=> tx_enabled_o || lk.locked)
    else $error("transmitter dropped without auto shutdown");
  a_enable_terms: assert property (
    tx_enabled_o |-> $past(want_on) && !$past(lk.locked))
    else $error("enabled without pin and soft bit");
  a_locked_off: assert property (lk.locked |=> !tx_enabled_o)
    else $error("transmitter on while locked");
  // judged at the latch, not at the gate, so a bad mask shows up
  a_detect_gate: assert property (
    (!faulted_o && !r_reg.setup[BIT_OVER_PWR] && r_reg.syn2[SYN_UP:SYN_OC] == 2'h0)
      |=> !faulted_o)
    else $error("disabled detector raised fault");
  a_reserved_zero: assert property (
    (cmd_rd_i && cmd_code_i == CMD_FAULT_SETUP) |=> cmd_rvalid_o && cmd_rdata_o[15:12] == 4'h0)
    else $error("reserved bits read nonzero");
  a_alarm_level: assert property (
    (drv == DRV_PUSH_PULL && !r_reg.setup[BIT_OVERRIDE] && r_reg.faulted)
      |=> alarm_out_o == $past(r_reg.setup[BIT_POLARITY]) && !alarm_oe_n_o)
    else $error("alarm not at active level");
  a_override_force: assert property (
    (drv == DRV_PUSH_PULL && r_reg.setup[BIT_OVERRIDE])
      |=> alarm_out_o == ($past(r_reg.setup[BIT_FORCE]) ~^ $past(r_reg.setup[BIT_POLARITY])))
    else $error("forced alarm level wrong");
  a_loop_owns: assert property (
    (tx_enabled_o && r_reg.setup[BIT_LOOP_EN]) |=> bias_current_setting_o == $past(loop_bias_i))
    else $error("loop value not applied");
  a_servo_zero: assert property (
    (!tx_enabled_o && !r_reg.setup[BIT_FAST_RESUME]) |=> r_reg.servo_bias == '0)
    else $error("servo value kept without fast resume");
  a_host_write: assert property (
    (cmd_wr_i && cmd_code_i == CMD_BIAS_SET && !r_reg.setup[BIT_LOOP_EN])
      |=> bias_current_setting_o == $past(cmd_wdata_i))
    else $error("host write lost with loop off");

  a_host_mod: assert property (
    (cmd_wr_i && cmd_code_i == CMD_MOD_SET && !r_reg.setup[BIT_LOOP_EN])
      |=> modulation_current_setting_o == $past(cmd_wdata_i))
    else $error("host modulation write lost with loop off");
  a_loop_mod: assert property (
    (tx_enabled_o && r_reg.setup[BIT_LOOP_EN])
      |=> modulation_current_setting_o == $past(loop_mod_i))
    else $error("loop modulation value not applied");

  // a lost servo copy would make a quick restart ramp from zero
  a_servo_keep: assert property (
    (!tx_enabled_o && r_reg.setup[BIT_FAST_RESUME]) |=> $stable(r_reg.servo_bias))
    else $error("servo value lost under fast resume");
  a_fast_load: assert property (
    (!tx_enabled_o && r_reg.setup[BIT_FAST_RESUME] && r_reg.setup[BIT_LOOP_EN]
      ##1 tx_enabled_o) |-> bias_current_setting_o == $past(r_reg.servo_bias))
    else $error("retained bias not loaded on enable");
  a_cold_load: assert property (
    (!tx_enabled_o && !r_reg.setup[BIT_FAST_RESUME] && r_reg.setup[BIT_LOOP_EN]
      ##1 tx_enabled_o)
      |-> bias_current_setting_o == '0 && modulation_current_setting_o == '0)
    else $error("currents did not restart from zero");

  a_open_drain: assert property ((drv != DRV_PUSH_PULL) |=> !alarm_out_o)
    else $error("open drain output drove high");
  a_pullup_weak: assert property (
    (drv == DRV_PULL_WEAK) |=> alarm_weak_pullup_o && !alarm_strong_pullup_o)
    else $error("weak pull-up not selected");
  a_pullup_strong: assert property (
    (drv == DRV_PULL_STRONG) |=> alarm_strong_pullup_o && !alarm_weak_pullup_o)
    else $error("strong pull-up not selected");
  a_pullup_off: assert property (
    (drv == DRV_OPEN_DRAIN || drv == DRV_PUSH_PULL)
      |=> !alarm_weak_pullup_o && !alarm_strong_pullup_o)
    else $error("pull-up on in plain drive mode");
  // pin level as seen outside: a released pin reads high through its pull-up
  a_alarm_active: assert property (
    (!r_reg.setup[BIT_OVERRIDE] && faulted_o)
      |=> (alarm_oe_n_o || alarm_out_o) == $past(r_reg.setup[BIT_POLARITY]))
    else $error("fault did not drive alarm active");
  a_override_quiet: assert property (
    (r_reg.setup[BIT_OVERRIDE] && !r_reg.setup[BIT_FORCE] && faulted_o)
      |=> (alarm_oe_n_o || alarm_out_o) != $past(r_reg.setup[BIT_POLARITY]))
    else $error("alarm active under override");
  a_fault_latch: assert property (fault_evt |=> faulted_o)
    else $error("fault not latched");

  c_auto_trip:  cover property (fault_evt && r_reg.setup[BIT_AUTO_SD] ##1 !tx_enabled_o);
  c_lockout:    cover property (!lk.locked ##1 lk.locked);
  c_fast_resume: cover property (!tx_enabled_o && r_reg.setup[BIT_FAST_RESUME] ##1 tx_enabled_o);
  c_push_pull_fault: cover property (drv == DRV_PUSH_PULL && faulted_o ##1 alarm_out_o);
  c_override_fault: cover property (r_reg.setup[BIT_OVERRIDE] && fault_evt);
endmodule : laser_fault_ctrl

// *** src/laser_fault_pkg.sv ***
package laser_fault_pkg;
  // command codes of the serial register interface
  localparam logic [7:0]  CMD_FAULT_SETUP = 8'h13;
  localparam logic [7:0]  CMD_BIAS_SET    = 8'h20;
  localparam logic [7:0]  CMD_MOD_SET     = 8'h21;
  localparam logic [7:0]  CMD_SYS_SETUP   = 8'h22;

  localparam int          DAC_W           = 16;
  localparam int          SETUP_W         = 12;
  localparam logic [11:0] SETUP_RESET     = 12'h4e7;
  localparam logic        SOFT_EN_RESET   = 1'b1;

  // field positions inside fault_handling_setup; BIT_SOFT_EN is in the system setup word
  localparam int BIT_REP_LOCK    = 11;
  localparam int BIT_FAST_RESUME = 10;
  localparam int BIT_DRV_HI      = 9;
  localparam int BIT_DRV_LO      = 8;
  localparam int BIT_LOOP_EN     = 7;
  localparam int BIT_AUTO_SD     = 6;
  localparam int BIT_POLARITY    = 5;
  localparam int BIT_OVERRIDE    = 4;
  localparam int BIT_FORCE       = 3;
  localparam int BIT_OVER_PWR    = 2;
  localparam int BIT_UNDER_PWR   = 1;
  localparam int BIT_OVER_CUR    = 0;
  localparam int BIT_SOFT_EN     = 0;

  // synchroniser lanes
  localparam int SYN_PIN = 0;
  localparam int SYN_OC  = 1;
  localparam int SYN_UP  = 2;
  localparam int SYN_OP  = 3;

  localparam logic [1:0] DRV_OPEN_DRAIN = 2'h0;
  localparam logic [1:0] DRV_PULL_WEAK  = 2'h1;
  localparam logic [1:0] DRV_PULL_STRONG = 2'h2;
  localparam logic [1:0] DRV_PUSH_PULL  = 2'h3;

  localparam int CLK_HZ         = 40_000_000;
  localparam int LOCK_WINDOW_MS = 25;
  localparam int LOCK_CYCLES    = LOCK_WINDOW_MS * (CLK_HZ / 1000);
  localparam int LOCK_CNT_W     = 20;

  typedef enum logic [1:0] {
    LK_IDLE   = 2'h0,
    LK_ONCE   = 2'h1,
    LK_WATCH  = 2'h3,
    LK_LOCKED = 2'h2
  } lock_state_t;
endpackage : laser_fault_pkg

// *** tb/host_model.sv ***
`timescale 1ns/1ps
module host_model (
  input  wire logic        sys_clk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  output logic [7:0]       code_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic [15:0]      wdata_o
);
  initial {code_o, wr_o, rd_o, wdata_o} = '0;
  // idle data is inverted so a stale word never passes for a write
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge sys_clk_i);
    code_o  <= c;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge sys_clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    d = 16'hxxxx;
    @(posedge sys_clk_i);
    code_o <= c;
    rd_o   <= 1'b1;
    @(posedge sys_clk_i);
    rd_o   <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk_i);
      if (rvalid_i === 1'b1) begin
        d = rdata_i;
        break;
      end
    end
  endtask : rd
endmodule : host_model

// *** tb/test_laser_fault_ctrl.sv ***
`timescale 1ns/1ps
module test_laser_fault_ctrl;
  import laser_fault_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        nrst_i    = 1'b0;
  logic        pin       = 1'b0;
  logic [2:0]  det       = 3'h0;
  logic [15:0] lb        = 16'h0aaa;
  logic [15:0] lm        = 16'h0bbb;
  logic [7:0]  code;
  logic        wr, rd, rvalid, tx_on, flt, once, twice, aout, oen, wpu, spu;
  logic [15:0] wdata, rdata, bias, modc, v;
  int          fails     = 0;
  int          n_checks  = 0;
  // board pull-up assumed when the alarm pin is released
  wire         apin      = oen ? 1'b1 : aout;

  always #12.5 sys_clk_i = ~sys_clk_i;

  laser_fault_ctrl #(.LOCK_CYC(20)) laser_fault_ctrl_i (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .tx_en_pin_i(pin),
    .over_power_i(det[2]), .under_power_i(det[1]), .over_current_i(det[0]),
    .loop_bias_i(lb), .loop_mod_i(lm), .cmd_code_i(code), .cmd_wr_i(wr),
    .cmd_rd_i(rd), .cmd_wdata_i(wdata), .cmd_rdata_o(rdata), .cmd_rvalid_o(rvalid),
    .tx_enabled_o(tx_on), .bias_current_setting_o(bias),
    .modulation_current_setting_o(modc), .faulted_o(flt), .faulted_once_o(once),
    .faulted_twice_o(twice), .alarm_out_o(aout), .alarm_oe_n_o(oen),
    .alarm_weak_pullup_o(wpu), .alarm_strong_pullup_o(spu));
  host_model host_model_i (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
    .code_o(code), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : tick
  task automatic set_up(input logic [15:0] s);
    host_model_i.wr(CMD_FAULT_SETUP, s);
    tick(3);
  endtask : set_up
  task automatic drive(input logic p, input logic [2:0] d, input int n);
    @(posedge sys_clk_i);
    pin <= p;
    det <= d;
    tick(n);
  endtask : drive
  // two-cycle pulse so the synchronisers always catch it
  task automatic pulse(input logic [2:0] d);
    drive(1'b1, d, 1);
    drive(1'b1, 3'h0, 5);
  endtask : pulse
  task automatic reenable();
    drive(1'b0, 3'h0, 6);
    drive(1'b1, 3'h0, 6);
  endtask : reenable
  task automatic restart(input logic [15:0] exp, input string what);
    drive(1'b0, 3'h0, 6);
    // move the live loop value so a retained one can be told apart
    @(posedge sys_clk_i);
    lb <= ~lb;
    drive(1'b1, 3'h0, 0);
    for (int k = 0; k < 8 && tx_on !== 1'b1; k++) tick(1);
    chk("restart enable", 16'h1, {15'h0, tx_on});
    chk(what, exp, bias);
  endtask : restart

  task automatic t_regs();
    host_model_i.rd(CMD_FAULT_SETUP, v);
    chk("setup after reset", 16'h04e7, v);
    host_model_i.wr(CMD_FAULT_SETUP, 16'hf4e7);
    host_model_i.rd(CMD_FAULT_SETUP, v);
    chk("reserved bits", 16'h04e7, v);
    host_model_i.rd(8'h55, v);
    chk("unmapped read", 16'h0000, v);
    $display("test regs done");
  endtask : t_regs
  task automatic t_alarm();
    for (int m = 0; m < 4; m++) begin
      set_up({6'h01, m[1:0], 8'he7});
      chk("weak pull-up", {15'h0, m == 1}, {15'h0, wpu});
      chk("strong pull-up", {15'h0, m == 2}, {15'h0, spu});
      chk("idle alarm", 16'h0, {15'h0, apin});
    end
    set_up(16'h04ef);
    chk("force without override", 16'h0, {15'h0, apin});
    set_up(16'h04ff);
    chk("forced open drain", 16'h3, {14'h0, oen, apin});
    set_up(16'h07ff);
    chk("forced push-pull", 16'h1, {14'h0, oen, aout});
    set_up(16'h04f7);
    chk("override inactive", 16'h0, {15'h0, apin});
    set_up(16'h04d7);
    chk("low polarity idle", 16'h1, {15'h0, apin});
    set_up(16'h04e7);
    $display("test alarm done");
  endtask : t_alarm
  task automatic t_faults();
    drive(1'b1, 3'h0, 6);
    chk("enable", 16'h1, {15'h0, tx_on});
    for (int d = 0; d < 3; d++) begin
      set_up(16'h04e7 & ~(16'h1 << d));
      pulse(3'h1 << d);
      chk("masked detector", 16'h0, {15'h0, flt});
      set_up(16'h04e7);
      pulse(3'h1 << d);
      chk("fault shutdown", 16'h5, {13'h0, flt, tx_on, apin});
      reenable();
      chk("fault cleared", 16'h2, {13'h0, flt, tx_on, apin});
    end
    set_up(16'h04f7);
    pulse(3'h1);
    chk("override fault", 16'h4, {13'h0, flt, tx_on, apin});
    reenable();
    set_up(16'h04a7);
    pulse(3'h4);
    chk("no auto shutdown", 16'h7, {13'h0, flt, tx_on, apin});
    set_up(16'h07a7);
    chk("push-pull fault", 16'h1, {14'h0, oen, aout});
    set_up(16'h0787);
    chk("active low fault", 16'h0, {14'h0, oen, aout});
    host_model_i.wr(CMD_SYS_SETUP, 16'h0000);
    tick(6);
    chk("soft disable", 16'h0, {15'h0, tx_on});
    host_model_i.wr(CMD_SYS_SETUP, 16'h0001);
    tick(6);
    chk("soft enable", 16'h1, {14'h0, flt, tx_on});
    $display("test faults done");
  endtask : t_faults
  task automatic t_currents();
    set_up(16'h0467);
    host_model_i.wr(CMD_BIAS_SET, 16'h1234);
    host_model_i.wr(CMD_MOD_SET, 16'h4321);
    tick(2);
    chk("host bias", 16'h1234, bias);
    chk("host modulation", 16'h4321, modc);
    set_up(16'h04e7);
    host_model_i.wr(CMD_BIAS_SET, 16'h1234);
    tick(3);
    chk("loop bias", lb, bias);
    chk("loop modulation", lm, modc);
    restart(lb, "fast resume bias");
    set_up(16'h00e7);
    restart(16'h0000, "cold start bias");
    $display("test currents done");
  endtask : t_currents
  task automatic t_lock();
    set_up(16'h0ce7);
    pulse(3'h1);
    chk("first fault", 16'h2, {14'h0, once, twice});
    reenable();
    pulse(3'h1);
    chk("second fault", 16'h1, {15'h0, twice});
    reenable();
    chk("locked off", 16'h0, {15'h0, tx_on});
    @(posedge sys_clk_i);
    nrst_i <= 1'b0;
    pin    <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    set_up(16'h0ce7);
    drive(1'b1, 3'h0, 6);
    pulse(3'h1);
    reenable();
    tick(30);
    chk("quiet window", 16'h0, {14'h0, once, twice});
    $display("test lock done");
  endtask : t_lock

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (8) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    tick(1);
    t_regs();
    t_alarm();
    t_faults();
    t_currents();
    t_lock();
    give_verdict();
  end
  initial begin
    #(25 * 6000);
    fails++;
    give_verdict();
  end
endmodule : test_laser_fault_ctrl
